// File: lbs_defines.vh
// Purpose: constants for the link and board status indicator block
// Assumes: 100 MHz hclk, eight camera links
// Notes: included by every design file of the block
`ifndef LBS_DEFINES_VH
`define LBS_DEFINES_VH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define LBS_NLINK 8
`define LBS_CW 27

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LBS_CLK_NS 10
`define LBS_FAST_HALF_NS 40000000
`define LBS_SLOW_HALF_NS 500000000
`define LBS_FAST_HALF_CYC (`LBS_FAST_HALF_NS / `LBS_CLK_NS)
`define LBS_SLOW_HALF_CYC (`LBS_SLOW_HALF_NS / `LBS_CLK_NS)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LBS_OFF_CTRL 12'h000
`define LBS_OFF_LINK_STATE 12'h004
`define LBS_OFF_BOARD 12'h008
`define LBS_OFF_LINK_IN 12'h00c

// ----------------------------------------------------------------
// control fields and reset
// ----------------------------------------------------------------
`define LBS_CTRL_INIT 0
`define LBS_CTRL_LAMP 1
`define LBS_CTRL_RST 32'h00000000

// ----------------------------------------------------------------
// link indicator states
// ----------------------------------------------------------------
`define LBS_ST_UNINIT 3'h0
`define LBS_ST_NOCAM 3'h1
`define LBS_ST_DET_PWR 3'h2
`define LBS_ST_DET 3'h3
`define LBS_ST_IDLE 3'h4
`define LBS_ST_TRIG 3'h5
`define LBS_ST_DATA 3'h6
`define LBS_ST_TEST 3'h7

// ----------------------------------------------------------------
// pcie status encodings
// ----------------------------------------------------------------
`define LBS_RATE_GEN3 2'h2
`define LBS_WIDTH_X8 4'h8

`endif

// File: lbs_cadence.v
// Purpose: free-running blink cadences shared by all link indicators and the board alive indicator
// Assumes: half periods given in hclk cycles
// Notes: pulse is lit for the first half of each slow high phase
`timescale 1ns/1ps
`include "lbs_defines.vh"

module lbs_cadence #(
    parameter FAST_HALF = `LBS_FAST_HALF_CYC,
    parameter SLOW_HALF = `LBS_SLOW_HALF_CYC
) (
    input wire hclk,
    input wire hresetn,
    output reg fast_phase,
    output reg slow_phase,
    output reg slow_pulse
);

    // full width first, then cut to the counter width on purpose
    localparam [31:0] FAST_END_W = FAST_HALF - 1;
    localparam [31:0] SLOW_END_W = SLOW_HALF - 1;
    localparam [31:0] PULSE_END_W = SLOW_HALF / 2;
    localparam [`LBS_CW-1:0] FAST_END = FAST_END_W[`LBS_CW-1:0];
    localparam [`LBS_CW-1:0] SLOW_END = SLOW_END_W[`LBS_CW-1:0];
    localparam [`LBS_CW-1:0] PULSE_END = PULSE_END_W[`LBS_CW-1:0];

    reg [`LBS_CW-1:0] fast_cnt;
    reg [`LBS_CW-1:0] slow_cnt;

    // ----------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fast_cnt <= {`LBS_CW{1'b0}};
            slow_cnt <= {`LBS_CW{1'b0}};
            fast_phase <= 1'b0;
            slow_phase <= 1'b0;
            slow_pulse <= 1'b0;
        end
        else
        begin
            // free running, so every link shares phase
            if (fast_cnt == FAST_END)
            begin
                fast_cnt <= {`LBS_CW{1'b0}};
                fast_phase <= ~fast_phase;
            end
            else
                fast_cnt <= fast_cnt + 1'b1;
            if (slow_cnt == SLOW_END)
            begin
                slow_cnt <= {`LBS_CW{1'b0}};
                slow_phase <= ~slow_phase;
            end
            else
                slow_cnt <= slow_cnt + 1'b1;
            slow_pulse <= slow_phase && (slow_cnt < PULSE_END);
        end
    end

endmodule

// File: lbs_link_led.v
// Purpose: one bi-colour link indicator
// Assumes: status inputs synchronous to hclk
// Notes: orange is green and red lit together
`timescale 1ns/1ps
`include "lbs_defines.vh"

module lbs_link_led (
    input wire hclk,
    input wire hresetn,
    input wire sys_init,
    input wire lamp_test,
    input wire cam_present,
    input wire detecting,
    input wire cable_power_supply,
    input wire data_active,
    input wire trig_wait,
    input wire test_packets,
    input wire fast_phase,
    input wire slow_phase,
    input wire slow_pulse,
    output reg [2:0] state,
    output reg led_green,
    output reg led_red
);

    reg [2:0] next_state;
    reg next_green;
    reg next_red;

    // ----------------------------------------------------------------
    // state priority
    // ----------------------------------------------------------------
    always @*
    begin
        if (!sys_init)
            next_state = `LBS_ST_UNINIT;
        else if (test_packets)
            next_state = `LBS_ST_TEST;
        else if (detecting)
            next_state = cable_power_supply ? `LBS_ST_DET_PWR : `LBS_ST_DET;
        else if (!cam_present)
            next_state = `LBS_ST_NOCAM;
        else if (data_active)
            next_state = `LBS_ST_DATA;
        else if (trig_wait)
            next_state = `LBS_ST_TRIG;
        else
            next_state = `LBS_ST_IDLE;
    end

    // ----------------------------------------------------------------
    // colour per state
    // ----------------------------------------------------------------
    always @*
    begin
        next_green = 1'b0;
        next_red = 1'b0;
        case (next_state)
            `LBS_ST_UNINIT:
            begin
                next_green = 1'b1;
                next_red = 1'b1;
            end
            `LBS_ST_NOCAM:
                next_red = slow_pulse;
            `LBS_ST_DET_PWR:
            begin
                next_green = 1'b1;
                next_red = fast_phase;
            end
            `LBS_ST_DET:
            begin
                next_green = fast_phase;
                next_red = fast_phase;
            end
            `LBS_ST_IDLE:
                next_green = 1'b1;
            `LBS_ST_TRIG:
            begin
                next_green = slow_pulse;
                next_red = slow_pulse;
            end
            `LBS_ST_DATA:
                next_green = fast_phase;
            `LBS_ST_TEST:
            begin
                next_green = 1'b1;
                next_red = slow_phase;
            end
            default:
            begin
                next_green = 1'b0;
                next_red = 1'b0;
            end
        endcase
        if (lamp_test)
        begin
            next_green = 1'b1;
            next_red = 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= `LBS_ST_UNINIT;
            led_green <= 1'b0;
            led_red <= 1'b0;
        end
        else
        begin
            state <= next_state;
            led_green <= next_green;
            led_red <= next_red;
        end
    end

endmodule

// File: lbs_top.v
// Purpose: link and board status indicators with an AHB-Lite register slave
// Assumes: status inputs synchronous to hclk; zero wait state bus
// Notes: orange is both colours of a bi-colour indicator lit
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "lbs_defines.vh"

module lbs_top #(
    parameter FAST_HALF = `LBS_FAST_HALF_CYC,
    parameter SLOW_HALF = `LBS_SLOW_HALF_CYC
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [`LBS_NLINK-1:0] cam_present,
    input wire [`LBS_NLINK-1:0] detecting,
    input wire [`LBS_NLINK-1:0] cable_power_supply,
    input wire [`LBS_NLINK-1:0] data_active,
    input wire [`LBS_NLINK-1:0] trig_wait,
    input wire [`LBS_NLINK-1:0] test_packets,
    input wire pcie_refclk_present,
    input wire pcie_in_l0,
    input wire [1:0] pcie_rate,
    input wire [3:0] pcie_width,
    output wire [`LBS_NLINK-1:0] link_led_green,
    output wire [`LBS_NLINK-1:0] link_led_red,
    output reg [3:0] board_led
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg [31:0] ctrl;
    reg wr_pend;
    reg [11:0] wr_addr;
    reg [31:0] next_rdata;
    reg [3:0] next_board;
    wire fast_phase;
    wire slow_phase;
    wire slow_pulse;
    wire addr_ok;
    wire [3*`LBS_NLINK-1:0] link_state;
    wire sys_init;
    wire lamp_test;

    assign sys_init = ctrl[`LBS_CTRL_INIT];
    assign lamp_test = ctrl[`LBS_CTRL_LAMP];

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && htrans[1] && hready;

    always @*
    begin
        next_rdata = 32'h00000000;
        case (haddr)
            `LBS_OFF_CTRL:
                next_rdata = ctrl;
            `LBS_OFF_LINK_STATE:
                next_rdata = {8'h00, link_state};
            `LBS_OFF_BOARD:
                next_rdata = {16'h0000, pcie_width, 2'b00, pcie_rate,
                    pcie_refclk_present, pcie_in_l0, 2'b00, board_led};
            `LBS_OFF_LINK_IN:
                next_rdata = {16'h0000, test_packets, cam_present};
            default:
                next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
            hrdata <= 32'h00000000;
        end
        else
        begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok)
                wr_addr <= haddr;
            if (addr_ok && !hwrite)
                hrdata <= next_rdata;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl <= `LBS_CTRL_RST;
        else if (wr_pend && (wr_addr == `LBS_OFF_CTRL))
            ctrl <= {30'h00000000, hwdata[1:0]};
    end

    // ----------------------------------------------------------------
    // shared cadence
    // ----------------------------------------------------------------
    lbs_cadence #(
        .FAST_HALF(FAST_HALF),
        .SLOW_HALF(SLOW_HALF)
    ) u_cadence (
        .hclk(hclk),
        .hresetn(hresetn),
        .fast_phase(fast_phase),
        .slow_phase(slow_phase),
        .slow_pulse(slow_pulse)
    );

    // ----------------------------------------------------------------
    // per-link indicators
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `LBS_NLINK; gi = gi + 1)
        begin : g_link
            // one independent indicator per link
            lbs_link_led u_led (
                .hclk(hclk),
                .hresetn(hresetn),
                .sys_init(sys_init),
                .lamp_test(lamp_test),
                .cam_present(cam_present[gi]),
                .detecting(detecting[gi]),
                .cable_power_supply(cable_power_supply[gi]),
                .data_active(data_active[gi]),
                .trig_wait(trig_wait[gi]),
                .test_packets(test_packets[gi]),
                .fast_phase(fast_phase),
                .slow_phase(slow_phase),
                .slow_pulse(slow_pulse),
                .state(link_state[3*gi+2:3*gi]),
                .led_green(link_led_green[gi]),
                .led_red(link_led_red[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // board indicators
    // ----------------------------------------------------------------
    always @*
    begin
        next_board[0] = pcie_refclk_present && slow_phase;
        next_board[1] = pcie_in_l0;
        next_board[2] = (pcie_rate == `LBS_RATE_GEN3);
        next_board[3] = (pcie_width == `LBS_WIDTH_X8);
        if (lamp_test)
            next_board = 4'hf;
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            board_led <= 4'h0;
        else
            board_led <= next_board;
    end

endmodule

// File: lbs_props.sv
// Purpose: port checker for the status indicator block
// Assumes: one clock domain, ctrl written only at offset 0
// Notes: mirrors ctrl writes to know the display mode
`timescale 1ns/1ps
module lbs_props #(
    parameter FAST_HALF = 4,
    parameter SLOW_HALF = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [7:0] cam_present,
    input wire [7:0] detecting,
    input wire [7:0] cable_power_supply,
    input wire [7:0] data_active,
    input wire [7:0] trig_wait,
    input wire [7:0] test_packets,
    input wire pcie_refclk_present,
    input wire pcie_in_l0,
    input wire [1:0] pcie_rate,
    input wire [3:0] pcie_width,
    input wire [7:0] link_led_green,
    input wire [7:0] link_led_red,
    input wire [3:0] board_led
);
    localparam int WIN = 2 * SLOW_HALF + 4;
    reg live;
    reg wp;
    reg [1:0] ctl;
    reg [1:0] ctl_q;
    reg [5:0] i0_q;
    reg [5:0] i1_q;
    wire run = live && ctl == 2'h1 && ctl_q == 2'h1;
    wire nl = live && !ctl_q[1];
    wire g0 = link_led_green[0];
    wire r0 = link_led_red[0];
    // --------------------------------
    // mode and input history
    // --------------------------------
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            live <= 1'b0;
            wp <= 1'b0;
            ctl <= 2'h0;
            ctl_q <= 2'h0;
            i0_q <= 6'h00;
            i1_q <= 6'h00;
        end
        else
        begin
            live <= 1'b1;
            wp <= hsel && htrans[1] && hready && hwrite && haddr == 12'h000;
            if (wp)
                ctl <= hwdata[1:0];
            ctl_q <= ctl;
            i0_q <= {cam_present[0], detecting[0], cable_power_supply[0],
                data_active[0], trig_wait[0], test_packets[0]};
            i1_q <= {cam_present[1], detecting[1], cable_power_supply[1],
                data_active[1], trig_wait[1], test_packets[1]};
        end
    end
    // --------------------------------
    // properties
    // --------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_l0; nl |-> board_led[1] == $past(pcie_in_l0); endproperty
    a_l0: assert property (p_l0) else $error("board led one wrong");
    property p_gen3; nl |-> board_led[2] == ($past(pcie_rate) == 2'h2); endproperty
    a_gen3: assert property (p_gen3) else $error("board led two wrong");
    property p_x8; nl |-> board_led[3] == ($past(pcie_width) == 4'h8); endproperty
    a_x8: assert property (p_x8) else $error("board led three wrong");
    property p_dark; nl && !$past(pcie_refclk_present) |-> !board_led[0]; endproperty
    a_dark: assert property (p_dark) else $error("alive led lit without clock");
    property p_alive;
        nl && pcie_refclk_present |-> ##[1:WIN] (board_led[0] || !pcie_refclk_present);
    endproperty
    a_alive: assert property (p_alive) else $error("alive led not blinking");
    property p_init;
        live && ctl == 2'h0 && ctl_q == 2'h0 |-> (&link_led_green) && (&link_led_red);
    endproperty
    a_init: assert property (p_init) else $error("links not orange before init");
    property p_nocam; run && i0_q == 6'h00 |-> !g0; endproperty
    a_nocam: assert property (p_nocam) else $error("green lit without camera");
    property p_detp; run && i0_q == 6'h18 |-> g0; endproperty
    a_detp: assert property (p_detp) else $error("powered detect not green based");
    property p_det; run && i0_q == 6'h10 |-> g0 == r0; endproperty
    a_det: assert property (p_det) else $error("detect flash not orange");
    property p_idle; run && i0_q == 6'h20 |-> g0 && !r0; endproperty
    a_idle: assert property (p_idle) else $error("idle link not green");
    property p_trig; run && i0_q == 6'h22 |-> g0 == r0; endproperty
    a_trig: assert property (p_trig) else $error("trigger pulse not orange");
    property p_data; run && i0_q == 6'h24 |-> !r0; endproperty
    a_data: assert property (p_data) else $error("data flash shows red");
    property p_test; run && i0_q == 6'h21 |-> g0; endproperty
    a_test: assert property (p_test) else $error("test flash green dropped");
    property p_same;
        live && i0_q == i1_q |-> g0 == link_led_green[1] && r0 == link_led_red[1];
    endproperty
    a_same: assert property (p_same) else $error("equal links differ");
    cover property (run && i0_q == 6'h24 && $rose(g0));
    cover property (live && ctl_q[1]);
    cover property (nl && $rose(board_led[0]));
endmodule

// File: lbs_tb.sv
// Purpose: self-checking bench for the status indicator block
// Assumes: zero wait state slave, short cadences
// Notes: checker bound below the module
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
$display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0, rate = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic [7:0] cam = 8'h0, det = 8'h0, pwr = 8'h0, dat = 8'h0, trg = 8'h0, tst = 8'h0;
    logic refclk = 1'h0, l0 = 1'h0;
    logic [3:0] width = 4'h1;
    wire hreadyout, hresp;
    wire [7:0] grn, red;
    wire [3:0] bled;
    int error_cnt = 0, checked = 0;
    always #5 hclk = ~hclk;
    lbs_top #(.FAST_HALF(4), .SLOW_HALF(16)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cam_present(cam), .detecting(det), .cable_power_supply(pwr),
        .data_active(dat), .trig_wait(trg), .test_packets(tst),
        .pcie_refclk_present(refclk), .pcie_in_l0(l0), .pcie_rate(rate),
        .pcie_width(width), .link_led_green(grn), .link_led_red(red), .board_led(bled));
    // --------------------------------
    // bus and helpers
    // --------------------------------
    task test_done;
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task wt;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 20)
        begin
            k++;
            @(posedge hclk);
        end
        if (k >= 20)
        begin
            error_cnt++;
            test_done;
        end
    endtask
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wt;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        rd = hrdata;
        `CHK("hresp", 1'h0, hresp)
    endtask
    task put(input logic [5:0] p);
        cam <= {8{p[5]}};
        det <= {8{p[4]}};
        pwr <= {8{p[3]}};
        dat <= {8{p[2]}};
        trg <= {8{p[1]}};
        tst <= {8{p[0]}};
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task t_reset;
        cyc(2);
        `CHK("green", 8'hff, grn)
        `CHK("red", 8'hff, red)
        ahb(1'h1, 12'h00c, 32'hffffffff);
        ahb(1'h0, 12'h010, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        ahb(1'h0, 12'h000, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        ahb(1'h1, 12'h000, 32'h1);
    endtask
    task t_mixed;
        cam <= 8'hf8;
        det <= 8'h86;
        pwr <= 8'h82;
        dat <= 8'ha0;
        trg <= 8'h10;
        tst <= 8'hc0;
        cyc(3);
        ahb(1'h0, 12'h004, 32'h0);
        `CHK("link_state", 24'hff58d1, rd[23:0])
        `CHK("idle_led", 2'h2, {grn[3], red[3]})
        ahb(1'h0, 12'h00c, 32'h0);
        `CHK("link_in", 16'hc0f8, rd[15:0])
    endtask
    task t_each;
        logic [5:0] pat [7];
        pat = '{6'h00, 6'h18, 6'h10, 6'h20, 6'h22, 6'h24, 6'h21};
        for (int i = 0; i < 7; i++)
        begin
            put(pat[i]);
            cyc(40);
            ahb(1'h0, 12'h004, 32'h0);
            `CHK("state", {8{3'(i + 1)}}, rd[23:0])
        end
    endtask
    task t_blink;
        int tg, tb0, bad;
        logic pg, pb;
        tg = 0;
        tb0 = 0;
        bad = 0;
        put(6'h24);
        refclk <= 1'h1;
        cyc(3);
        #1;
        pg = grn[0];
        pb = bled[0];
        repeat (64)
        begin
            @(posedge hclk);
            #1;
            tg += (grn[0] !== pg);
            tb0 += (bled[0] !== pb);
            bad += (grn !== {8{grn[0]}}) || (red !== 8'h00);
            pg = grn[0];
            pb = bled[0];
        end
        `CHK("fast_toggles", 1'h1, tg >= 15 && tg <= 17)
        `CHK("in_phase", 0, bad)
        `CHK("alive_toggles", 1'h1, tb0 >= 3 && tb0 <= 5)
        cyc(1);
        refclk <= 1'h0;
        cyc(3);
        `CHK("alive_off", 1'h0, bled[0])
    endtask
    task t_board;
        for (int i = 0; i < 3; i++)
        begin
            rate <= 2'(i);
            width <= (i == 1) ? 4'h8 : (i == 0) ? 4'h1 : 4'h4;
            l0 <= i[0];
            cyc(3);
            `CHK("board", {i == 1, i == 2, i[0]}, bled[3:1])
        end
        ahb(1'h1, 12'h000, 32'h3);
        cyc(3);
        `CHK("lamp", 20'hfffff, {grn, red, bled})
        ahb(1'h1, 12'h000, 32'h1);
    endtask
    task t_rerun;
        hresetn <= 1'h0;
        cyc(2);
        `CHK("rst_leds", 20'h00000, {grn, red, bled})
        `CHK("rst_rdata", 32'h0, hrdata)
        hresetn <= 1'h1;
        cyc(2);
        `CHK("green", 8'hff, grn)
        `CHK("red", 8'hff, red)
        ahb(1'h0, 12'h000, 32'h0);
        `CHK("ctrl", 32'h0, rd)
    endtask
    initial
    begin
        cyc(5);
        hresetn <= 1'h1;
        t_reset;
        t_mixed;
        t_each;
        t_blink;
        t_board;
        t_rerun;
        test_done;
    end
endmodule
bind lbs_top lbs_props #(.FAST_HALF(FAST_HALF), .SLOW_HALF(SLOW_HALF)) u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .cam_present(cam_present),
    .detecting(detecting), .cable_power_supply(cable_power_supply),
    .data_active(data_active), .trig_wait(trig_wait), .test_packets(test_packets),
    .pcie_refclk_present(pcie_refclk_present), .pcie_in_l0(pcie_in_l0),
    .pcie_rate(pcie_rate), .pcie_width(pcie_width), .link_led_green(link_led_green),
    .link_led_red(link_led_red), .board_led(board_led));
